// ===== lan_mark_defines.vh
// Functional notes
// R1: Publish group zero disables all other selectors
// R2: Output-source group drives connector outputs
// R3: Output-source zero drives outputs from own values
// R4: Eight groups of sixty-four consecutive marks
// R5: Tool code, enables, strobes, emergency, jog
// R6: Positions 33-47 carry decode table bits
// R7: Input-source group updates internal input variables
// R8: Input-source zero updates from connector inputs
// R9: Positions 1-11 map start through V home
// R10: Selector zero takes flags from system call
// R11: Nonzero additional selector names flag group
// R12: Inhibit, done, double compensation from mark/bit
// R13: Integrated logic publishes own group, reads others
// R14: Integrated logic ignores the three other selectors
// R15: Remote node picks broadcast group in field
// R16: Publish group broadcasts inputs and own outputs; code sends inputs and ctrl_status, not ctrl_conn_out
// R17: Positions 1-11 inputs, 12-59 status
// R18: Exchange once per scan, hold consumed values
`ifndef LAN_MARK_DEFINES_VH
`define LAN_MARK_DEFINES_VH
// Register byte offsets
`define CFG_OFF 8'h00
`define STAT_OFF 8'h04
`define SCAN_OFF 8'h08
// Configuration field positions
`define PUB_LSB 0
`define OUT_LSB 4
`define IN_LSB 8
`define ADD_LSB 12
`define ILOG_BIT 16
`define CFG_RST 32'h00000000
// Group geometry
`define NUM_GROUPS 8
`define GROUP_MARKS 64
`define SEL_MAX 4'h8
// Mark positions inside a group (1-based)
`define POS_IN_FIRST 1
`define POS_IN_LAST 11
`define POS_STAT_FIRST 12
`define POS_STAT_LAST 59
`define POS_OUT_FIRST 17
`define POS_OUT_LAST 48
`define POS_INHIBIT 49
`define POS_DONE 50
`define POS_DCC 53
// Additional flag bits in the call register
`define AFR_INHIBIT 0
`define AFR_DONE 1
`define AFR_DCC 4
`endif

// ===== pin_sync.v
`timescale 1ns/1ps
module pin_sync #(
   parameter WIDTH = 11
) (
   input wire core_clk,
   input wire rst,
   input wire [WIDTH-1:0] pin,
   output reg [WIDTH-1:0] synced
);
   reg [WIDTH-1:0] meta;

   // Two stages; only the second stage is read outside
   always @(posedge core_clk) begin
      if (rst) begin
         meta <= {WIDTH{1'b0}};
         synced <= {WIDTH{1'b0}};
      end else begin
         meta <= pin;
         synced <= meta;
      end
   end
endmodule

// ===== mark_store.v
`timescale 1ns/1ps
module mark_store #(
   parameter GROUPS = 8,
   parameter MARKS = 64,
   parameter AW = 3,
   parameter PORTS = 4
) (
   input wire core_clk,
   input wire rst,
   input wire wr_en,
   input wire [AW-1:0] wr_group,
   input wire [MARKS-1:0] wr_marks,
   input wire [PORTS*AW-1:0] rd_groups,
   output reg [PORTS*MARKS-1:0] rd_marks
);
   reg [MARKS-1:0] mem [0:GROUPS-1];
   integer g;
   integer p;

   // Each group keeps its last broadcast until the next one arrives
   always @(posedge core_clk) begin
      if (rst) begin
         for (g = 0; g < GROUPS; g = g + 1)
            mem[g] <= {MARKS{1'b0}};
      end else if (wr_en) begin
         mem[wr_group] <= wr_marks; // [R18]
      end
   end

   // Combinational read ports
   always @* begin
      rd_marks = {PORTS*MARKS{1'b0}};
      for (p = 0; p < PORTS; p = p + 1)
         rd_marks[p*MARKS +: MARKS] = mem[rd_groups[p*AW +: AW]];
   end
endmodule

// ===== lan_mark_group_exchange.v
`timescale 1ns/1ps
`include "lan_mark_defines.vh"
module lan_mark_group_exchange (
   input wire core_clk,
   input wire rst,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   // Physical connector inputs (asynchronous pins)
   input wire [10:0] conn_in,
   // Controller's own values
   input wire [47:0] ctrl_status,
   input wire [31:0] ctrl_conn_out,
   // Connector outputs and internal variables
   output reg [31:0] conn_out,
   output reg [10:0] internal_in,
   output reg transfer_inhibit,
   output reg function_done,
   output reg double_cross_comp,
   // System call path for the additional flags
   input wire [15:0] additional_flags_reg,
   input wire additional_flags_call_mark,
   // Network side
   input wire scan_tick,
   input wire rx_valid,
   input wire [2:0] rx_group,
   input wire [63:0] rx_marks,
   output reg tx_valid,
   output reg [2:0] tx_group,
   output reg [63:0] tx_marks,
   // Integrated logic variant
   input wire [63:0] ilogic_marks,
   input wire [2:0] ilogic_rd_group,
   output reg [63:0] ilogic_rd_marks
);
   // Configuration, scan count and latched call flags
   reg [31:0] cfg;
   reg [31:0] scan_count;
   reg [2:0] call_flags;
   wire [10:0] conn_sync;
   wire [3:0] pub_sel;
   wire [3:0] out_raw;
   wire [3:0] in_raw;
   wire [3:0] add_raw;
   wire ilog;
   wire pub_on;
   wire [3:0] out_sel;
   wire [3:0] in_sel;
   wire [3:0] add_sel;
   wire conflict;
   wire [11:0] rd_groups;
   wire [255:0] rd_marks;
   wire [63:0] out_word;
   wire [63:0] in_word;
   wire [63:0] add_word;
   wire [63:0] pub_word;
   wire [63:0] own_word;
   wire wr_acc;
   wire rd_setup;
   wire [2:0] hit;
   wire tx_fire;
   wire [2:0] pub_idx;
   wire [2:0] net_flags;
   wire [31:0] stat_word;

   // A selector names a group only within 1..8
   function grp_ok;
      input [3:0] s;
      begin
         grp_ok = (s != 4'h0) && (s <= `SEL_MAX);
      end
   endfunction

   // Effective consumer selector: local when publish is off,
   // when out of range, or when it repeats the publish group
   function [3:0] eff_sel;
      input [3:0] s;
      input [3:0] pub;
      input il;
      begin
         if (!grp_ok(pub) || il || !grp_ok(s) || s == pub)
            eff_sel = 4'h0;
         else
            eff_sel = s;
      end
   endfunction

   // Group number 1..8 to store index 0..7
   function [2:0] grp_idx;
      input [3:0] s;
      reg [3:0] t;
      begin
         t = s - 4'h1;
         grp_idx = t[2:0];
      end
   endfunction

   // Mark at a 1-based position of a group word
   function mark_at;
      input [63:0] w;
      input integer pos;
      begin
         mark_at = w[pos-1];
      end
   endfunction

   // Offset decode shared by the write path and the error flag
   function [2:0] reg_hit;
      input [7:0] a;
      begin
         reg_hit[0] = (a == `CFG_OFF);
         reg_hit[1] = (a == `STAT_OFF);
         reg_hit[2] = (a == `SCAN_OFF);
      end
   endfunction

   // Pins cross into the core clock before anything reads them
   pin_sync #(
      .WIDTH(11)
   ) u_conn_sync (
      .core_clk(core_clk),
      .rst(rst),
      .pin(conn_in),
      .synced(conn_sync)
   );

   // Configuration fields
   assign pub_sel = cfg[`PUB_LSB +: 4];
   assign out_raw = cfg[`OUT_LSB +: 4];
   assign in_raw = cfg[`IN_LSB +: 4];
   assign add_raw = cfg[`ADD_LSB +: 4];
   assign ilog = cfg[`ILOG_BIT];
   assign pub_on = grp_ok(pub_sel); // [R1] [R16]

   // Consumer selectors collapse to local when not usable
   assign out_sel = eff_sel(out_raw, pub_sel, ilog); // [R1] [R2] [R14]
   assign in_sel = eff_sel(in_raw, pub_sel, ilog); // [R1] [R7] [R14]
   assign add_sel = eff_sel(add_raw, pub_sel, ilog); // [R1] [R11] [R14]

   // Flags a selector that equals the publish group
   assign conflict = pub_on && !ilog &&
      ((out_raw == pub_sel) || (in_raw == pub_sel) ||
      (add_raw == pub_sel));

   // Four read ports: outputs, inputs, additional, integrated logic
   assign rd_groups = {ilogic_rd_group,
      grp_idx(add_sel),
      grp_idx(in_sel),
      grp_idx(out_sel)};

   // Shared mark space of eight groups of 64
   mark_store #(
      .GROUPS(`NUM_GROUPS),
      .MARKS(`GROUP_MARKS),
      .AW(3),
      .PORTS(4)
   ) u_store (
      .core_clk(core_clk),
      .rst(rst),
      .wr_en(rx_valid),
      .wr_group(rx_group),
      .wr_marks(rx_marks),
      .rd_groups(rd_groups),
      .rd_marks(rd_marks)
   ); // [R4]

   assign out_word = rd_marks[63:0];
   assign in_word = rd_marks[127:64];
   assign add_word = rd_marks[191:128];

   // Word broadcast by the controller: inputs then status
   assign own_word = {5'h00, ctrl_status, conn_sync}; // [R17]
   assign pub_word = ilog ? ilogic_marks : own_word; // [R13]

   // A publish fires only on a scan with a usable publish group
   assign tx_fire = scan_tick && pub_on; // [R16] [R18]
   assign pub_idx = grp_idx(pub_sel);

   // Broadcast once per scan on the publish group
   always @(posedge core_clk) begin
      if (rst) begin
         tx_valid <= 1'b0;
         tx_group <= 3'h0;
         tx_marks <= 64'h0000000000000000;
      end else begin
         tx_valid <= tx_fire; // [R16] [R18]
         if (tx_fire) begin
            tx_group <= pub_idx; // [R16]
            tx_marks <= pub_word; // [R3] [R8] [R13]
         end
      end
   end

   // Connector outputs: network group at scan, else own values
   always @(posedge core_clk) begin
      if (rst) begin
         conn_out <= 32'h00000000;
      end else if (out_sel == 4'h0) begin
         conn_out <= ctrl_conn_out; // [R3]
      end else if (scan_tick) begin
         conn_out <= out_word[`POS_OUT_LAST-1:`POS_OUT_FIRST-1]; // [R2] [R5] [R6] [R18]
      end
   end

   // Internal inputs: network group at scan, else the pins
   always @(posedge core_clk) begin
      if (rst) begin
         internal_in <= 11'h000;
      end else if (in_sel == 4'h0) begin
         internal_in <= conn_sync; // [R8]
      end else if (scan_tick) begin
         internal_in <= in_word[`POS_IN_LAST-1:`POS_IN_FIRST-1]; // [R7] [R9] [R18]
      end
   end

   // Flags from the system call are held until the next call
   always @(posedge core_clk) begin
      if (rst) begin
         call_flags <= 3'h0;
      end else if (additional_flags_call_mark) begin
         call_flags[0] <= additional_flags_reg[`AFR_INHIBIT]; // [R10] [R12]
         call_flags[1] <= additional_flags_reg[`AFR_DONE]; // [R12]
         call_flags[2] <= additional_flags_reg[`AFR_DCC]; // [R12]
      end
   end

   // Additional flags picked from their mark positions in the group
   assign net_flags = {mark_at(add_word, `POS_DCC), mark_at(add_word, `POS_DONE),
      mark_at(add_word, `POS_INHIBIT)};

   // Additional flags: mark group when selected, else call register
   always @(posedge core_clk) begin
      if (rst) begin
         transfer_inhibit <= 1'b0;
         function_done <= 1'b0;
         double_cross_comp <= 1'b0;
      end else if (add_sel == 4'h0) begin
         transfer_inhibit <= call_flags[0]; // [R10]
         function_done <= call_flags[1];
         double_cross_comp <= call_flags[2];
      end else if (scan_tick) begin
         transfer_inhibit <= net_flags[0]; // [R11] [R12] [R18]
         function_done <= net_flags[1]; // [R12]
         double_cross_comp <= net_flags[2]; // [R12]
      end
   end

   // Integrated logic may read any group others wrote
   always @(posedge core_clk) begin
      if (rst) begin
         ilogic_rd_marks <= 64'h0000000000000000;
      end else begin
         ilogic_rd_marks <= rd_marks[255:192]; // [R13]
      end
   end

   // Scan counter lets software see the exchange running
   always @(posedge core_clk) begin
      if (rst) begin
         scan_count <= 32'h00000000;
      end else if (scan_tick) begin
         scan_count <= scan_count + 32'h00000001;
      end
   end

   // Status word: publish state, conflict, flags, inputs
   assign stat_word = {16'h0000, pub_on, conflict, double_cross_comp,
      function_done, transfer_inhibit, internal_in};

   // APB: zero wait states, writes land in the access phase
   assign pready = 1'b1;
   assign wr_acc = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign hit = reg_hit(paddr);
   assign pslverr = psel && penable && (hit == 3'h0);

   // Only the configuration word is writable
   always @(posedge core_clk) begin
      if (rst) begin
         cfg <= `CFG_RST;
      end else if (wr_acc && hit[0]) begin
         cfg <= {15'h0000, pwdata[16:0]};
      end
   end

   // Read data is captured in setup so it is stable in access
   always @(posedge core_clk) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (rd_setup) begin
         case (paddr)
            `CFG_OFF: prdata <= cfg;
            `STAT_OFF: prdata <= stat_word;
            `SCAN_OFF: prdata <= scan_count;
            default: prdata <= 32'h00000000;
         endcase
      end
   end
endmodule

// ===== logic_node_model.sv
`timescale 1ns/1ps
module logic_node_model (
   input wire core_clk,
   input wire rst,
   input wire go,
   input wire [15:0] remote_exchange_config_reg,
   input wire [63:0] word,
   output reg rx_valid,
   output reg [2:0] rx_group,
   output reg [63:0] rx_marks
);
   // One broadcast per request; afterwards the lines show the inverse once, so a late sample is caught
   always @(posedge core_clk) begin
      if (rst) begin
         rx_valid <= 1'h0;
         rx_group <= 3'h0;
         rx_marks <= 64'h0;
      end else if (go) begin
         rx_valid <= 1'h1;
         rx_group <= remote_exchange_config_reg[10:8] - 3'h1;
         rx_marks <= word;
      end else begin
         rx_valid <= 1'h0;
         if (rx_valid)
            rx_marks <= ~rx_marks;
      end
   end
endmodule

// ===== mark_exchange_checker.sv
`timescale 1ns/1ps
module mark_exchange_checker (
   input wire core_clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [47:0] ctrl_status,
   input wire [31:0] ctrl_conn_out,
   input wire scan_tick,
   input wire rx_valid,
   input wire [2:0] rx_group,
   input wire [63:0] rx_marks,
   input wire [31:0] conn_out,
   input wire [10:0] internal_in,
   input wire transfer_inhibit,
   input wire tx_valid,
   input wire [2:0] tx_group,
   input wire [63:0] tx_marks
);
   reg [16:0] cfg;
   reg [63:0] mem [0:7];
   integer j;
   wire [3:0] pub = cfg[3:0];
   wire pub_ok = pub != 4'h0 && pub <= 4'h8;
   wire [63:0] ow = mem[cfg[6:4] - 3'h1];
   wire [63:0] iw = mem[cfg[10:8] - 3'h1];
   wire [63:0] aw = mem[cfg[14:12] - 3'h1];
   // Shadow of the configuration word and of every received group
   always @(posedge core_clk) begin
      if (rst) begin
         cfg <= 17'h00000;
         for (j = 0; j < 8; j = j + 1)
            mem[j] <= 64'h0;
      end else begin
         if (psel && penable && pwrite && paddr == 8'h00)
            cfg <= pwdata[16:0];
         if (rx_valid)
            mem[rx_group] <= rx_marks;
      end
   end
   // Own group, out of range or integrated logic all mean local source
   function loc(input [3:0] s);
      loc = !pub_ok || cfg[16] || s == 4'h0 || s > 4'h8 || s == pub;
   endfunction
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   tick_publish_a:
      assert property (scan_tick && pub_ok |=> tx_valid && tx_group == $past(pub[2:0]) - 3'h1) else $error("no publish");
   no_publish_a:
      assert property (!(scan_tick && pub_ok) |=> !tx_valid) else $error("stray publish");
   publish_word_a:
      assert property (scan_tick && pub_ok && !cfg[16] |=> tx_marks[63:11] == {5'h00, $past(ctrl_status)})
      else $error("bad word");
   local_out_a:
      assert property (!rst && loc(cfg[7:4]) |=> conn_out == $past(ctrl_conn_out)) else $error("bad local out");
   out_hold_a:
      assert property (!loc(cfg[7:4]) && !scan_tick |=> $stable(conn_out)) else $error("out not held");
   net_out_a:
      assert property (scan_tick && !loc(cfg[7:4]) |=> conn_out == $past(ow[47:16])) else $error("bad net out");
   net_in_a:
      assert property (scan_tick && !loc(cfg[11:8]) |=> internal_in == $past(iw[10:0])) else $error("bad net in");
   net_flag_a:
      assert property (scan_tick && !loc(cfg[15:12]) |=> transfer_inhibit == $past(aw[48])) else $error("bad flag");
endmodule
bind lan_mark_group_exchange mark_exchange_checker chk (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
   .ctrl_status, .ctrl_conn_out, .scan_tick, .rx_valid, .rx_group, .rx_marks, .conn_out, .internal_in,
   .transfer_inhibit, .tx_valid, .tx_group, .tx_marks);

// ===== lan_mark_group_exchange_tb.sv
`timescale 1ns/1ps
module lan_mark_group_exchange_tb;
   localparam [63:0] NW = 64'h0010A5C39E710B6D;
   localparam [63:0] NW2 = ~NW;
   localparam [31:0] LO = 32'h13579BDF;
   localparam [10:0] PI = 11'h5A3;
   localparam [47:0] ST = 48'h123456789ABC;
   localparam [63:0] IL = 64'hC0DE000011112222;
   reg core_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   reg scan_tick = 1'h0, go = 1'h0, additional_flags_call_mark = 1'h0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0, ctrl_conn_out = LO;
   reg [10:0] conn_in = PI;
   reg [47:0] ctrl_status = ST;
   reg [15:0] additional_flags_reg = 16'h0001;
   reg [63:0] word = NW, ilogic_marks = IL;
   reg [2:0] ilogic_rd_group = 3'h0;
   wire pready, pslverr, rx_valid, tx_valid, transfer_inhibit, function_done, double_cross_comp;
   wire [31:0] prdata, conn_out;
   wire [10:0] internal_in;
   wire [2:0] rx_group, tx_group;
   wire [63:0] rx_marks, tx_marks, ilogic_rd_marks;
   reg [60:0] rows [0:5];
   reg [60:0] r;
   reg [31:0] d;
   reg e;
   integer i, n_errors = 0, comparisons = 0;
   lan_mark_group_exchange dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
      .pslverr, .conn_in, .ctrl_status, .ctrl_conn_out, .conn_out, .internal_in, .transfer_inhibit, .function_done,
      .double_cross_comp, .additional_flags_reg, .additional_flags_call_mark, .scan_tick, .rx_valid, .rx_group,
      .rx_marks, .tx_valid, .tx_group, .tx_marks, .ilogic_marks, .ilogic_rd_group, .ilogic_rd_marks);
   // Far node broadcasts on group 2: only bit 9 of its field set
   logic_node_model node (.core_clk, .rst, .go, .remote_exchange_config_reg(16'h0200), .word, .rx_valid,
      .rx_group, .rx_marks);
   initial forever #4 core_clk = ~core_clk;
   task stop_test;
      begin
         $display("errors %0d comparisons %0d", n_errors, comparisons);
         if (n_errors == 0 && comparisons > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   task check(input [63:0] s, input [63:0] x);
      begin
         comparisons = comparisons + 1;
         if (s !== x) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %0t seen %h expected %h", $time, s, x);
         end
      end
   endtask
   // Bounded wait for pready; a hang ends the run
   task apb(input w, input [7:0] a, input [31:0] wd, output [31:0] rd, output er);
      integer k;
      begin
         psel <= 1'h1;
         pwrite <= w;
         paddr <= a;
         pwdata <= wd;
         @(posedge core_clk);
         penable <= 1'h1;
         k = 0;
         do begin
            @(posedge core_clk);
            k = k + 1;
         end while (pready !== 1'h1 && k < 20);
         if (pready !== 1'h1) begin
            n_errors = n_errors + 1;
            stop_test;
         end
         rd = prdata;
         er = pslverr;
         psel <= 1'h0;
         penable <= 1'h0;
         @(posedge core_clk);
      end
   endtask
   task tick;
      begin
         scan_tick <= 1'h1;
         @(posedge core_clk);
         scan_tick <= 1'h0;
         repeat (4) @(posedge core_clk);
      end
   endtask
   task send(input [63:0] w);
      begin
         word <= w;
         go <= 1'h1;
         @(posedge core_clk);
         go <= 1'h0;
         repeat (3) @(posedge core_clk);
      end
   endtask
   // Rows: config word, then expected outputs, internal inputs and flag
   initial begin
      rows[0] = {17'h00000, LO, PI, 1'h1};
      rows[1] = {17'h02221, NW[47:16], NW[10:0], NW[48]};
      rows[2] = {17'h00201, LO, NW[10:0], 1'h1};
      rows[3] = {17'h02222, LO, PI, 1'h1};
      rows[4] = {17'h12221, LO, PI, 1'h1};
      rows[5] = {17'h02229, LO, PI, 1'h1};
      repeat (2) @(posedge core_clk);
      check(conn_out, 64'h0);
      check(tx_valid, 64'h0);
      rst <= 1'h0;
      @(posedge core_clk);
      send(NW);
      additional_flags_call_mark <= 1'h1;
      @(posedge core_clk);
      additional_flags_call_mark <= 1'h0;
      for (i = 0; i < 6; i = i + 1) begin
         r = rows[i];
         apb(1'h1, 8'h00, {15'h0000, r[60:44]}, d, e);
         tick;
         check(conn_out, r[43:12]);
         check(internal_in, r[11:1]);
         check(transfer_inhibit, r[0]);
         if (r[47:44] != 4'h0 && r[47:44] < 4'h9) begin
            check(tx_marks, r[60] ? IL : {5'h00, ST, PI});
            check(tx_group, {61'h0, r[46:44] - 3'h1});
         end
      end
      // A new broadcast alone must not move the outputs before the next scan
      apb(1'h1, 8'h00, 32'h00002221, d, e);
      tick;
      send(NW2);
      check(conn_out, NW[47:16]);
      tick;
      check(conn_out, NW2[47:16]);
      check(function_done, NW2[49]);
      check(double_cross_comp, NW2[52]);
      ilogic_rd_group <= 3'h1;
      repeat (2) @(posedge core_clk);
      check(ilogic_rd_marks, NW2);
      apb(1'h0, 8'h04, 32'h0, d, e);
      check(d, {32'h0, 16'h0, 2'h2, NW2[52], NW2[49], NW2[48], NW2[10:0]});
      apb(1'h0, 8'h00, 32'h0, d, e);
      check(d, 64'h2221);
      apb(1'h0, 8'h0C, 32'h0, d, e);
      check(d, 64'h0);
      check(e, 64'h1);
      apb(1'h0, 8'h08, 32'h0, d, e);
      check(d, 64'h8);
      // Reset in mid-run clears the store and returns every source to local
      rst <= 1'h1;
      repeat (2) @(posedge core_clk);
      rst <= 1'h0;
      check(conn_out, 64'h0);
      check(function_done, 64'h0);
      repeat (4) @(posedge core_clk);
      check(conn_out, LO);
      check(ilogic_rd_marks, 64'h0);
      check(tx_valid, 64'h0);
      stop_test;
   end
endmodule
